// >>> rtl/kic_pkg.sv
package kic_pkg;

  // ---------------------------------------------------------------------
  // Special function register addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_INT_ENABLE_MAIN       = 8'hA8;
  localparam logic [7:0] ADDR_INT_ENABLE_EXTENDED   = 8'hA9;
  localparam logic [7:0] ADDR_INT_PRIORITY_MAIN     = 8'hB8;
  localparam logic [7:0] ADDR_INT_PRIORITY_EXTENDED = 8'hB9;
  localparam logic [7:0] ADDR_LINE_LEVEL_POLARITY   = 8'hFD;
  localparam logic [7:0] ADDR_LINE_SOURCE_ENABLE    = 8'hFE;
  localparam logic [7:0] ADDR_LINE_DETECT_FLAGS     = 8'hFF;

  // ---------------------------------------------------------------------
  // Reset values and writable bit masks
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_REG          = 8'h00;
  localparam logic [7:0] MASK_ENABLE_MAIN = 8'hBF;
  localparam logic [7:0] MASK_LOW_SIX     = 8'h3F;
  localparam logic [7:0] MASK_LOW_TWO     = 8'h03;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int BIT_GLOBAL_INT_ENABLE     = 7;
  localparam int BIT_KEYPAD_GROUP          = 0;
  localparam int BIT_COUNTER_ARRAY         = 1;
  localparam int NUM_SOURCES               = 8;
  localparam int SRC_KEYPAD                = 6;

  // ---------------------------------------------------------------------
  // Vectors: source index n sits at base + step * n
  // ---------------------------------------------------------------------
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam logic [15:0] VECTOR_STEP = 16'h0008;

  typedef enum logic [1:0] {
    KIC_IDLE,
    KIC_LOW_ACTIVE,
    KIC_HIGH_ACTIVE,
    KIC_BOTH_ACTIVE
  } kic_level_t;

endpackage

// >>> rtl/kic_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Polarity bit 0 detects low, 1 high
// - Register bit n maps to keypad line n
// - Enable 0 plain pin, 1 allows request
// - Hardware sets flag on selected line level
// - Flag requests only when line enabled
// - Flags read-only, cleared by reading them
// - Eight vectors 0003h step eight, fixed polling
// - Each source has its own enable bit
// - Global enable zero blocks all acknowledges
// - Main enable bits five to zero mapping
// - Extended enable: counter array, keypad group
// - Main priority bits five to zero mapping
// - Extended priority: counter array, keypad group
// - Keypad lines on port one wake device
// - Eight keypad lines share one vector
module kic_ctrl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  output logic             o_sfr_hit,
  input  wire logic [7:0]  i_port1,
  input  wire logic [5:0]  i_periph_req,
  input  wire logic        i_counter_array_req,
  output logic             o_irq,
  output logic      [15:0] o_irq_vector,
  output logic      [2:0]  o_irq_source,
  input  wire logic        i_irq_ack,
  input  wire logic        i_reti,
  output logic      [7:0]  o_keypad_line_enable,
  output logic             o_wake,
  output logic             o_expanded_keypad_interrupt,
  output kic_pkg::kic_level_t o_active_level
);
  import kic_pkg::*;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [7:0] int_enable_main;
  logic [7:0] int_enable_extended;
  logic [7:0] int_priority_main;
  logic [7:0] int_priority_extended;
  logic [7:0] line_level_polarity;
  logic [7:0] line_source_enable;
  logic [7:0] line_detect_flags;
  logic [7:0] port_sync1;
  logic [7:0] port_sync2;
  logic       high_active;
  logic       low_active;

  // Picks the lowest-numbered set bit, which is the polling order.
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  wire sel_iem  = (i_sfr_addr == ADDR_INT_ENABLE_MAIN);
  wire sel_iex  = (i_sfr_addr == ADDR_INT_ENABLE_EXTENDED);
  wire sel_ipm  = (i_sfr_addr == ADDR_INT_PRIORITY_MAIN);
  wire sel_ipx  = (i_sfr_addr == ADDR_INT_PRIORITY_EXTENDED);
  wire sel_pol  = (i_sfr_addr == ADDR_LINE_LEVEL_POLARITY);
  wire sel_sen  = (i_sfr_addr == ADDR_LINE_SOURCE_ENABLE);
  wire sel_flg  = (i_sfr_addr == ADDR_LINE_DETECT_FLAGS);
  wire any_sel  = sel_iem | sel_iex | sel_ipm | sel_ipx | sel_pol
                | sel_sen | sel_flg;
  wire flag_rd  = i_sfr_rd & sel_flg;

  // ---------------------------------------------------------------------
  // Keypad detection
  // ---------------------------------------------------------------------
  // A line matches when the synchronised level equals its polarity bit.
  wire [7:0] line_match   = ~(port_sync2 ^ line_level_polarity);
  wire [7:0] next_flags   = line_match
                          | (flag_rd ? 8'h00 : line_detect_flags);
  wire [7:0] line_request = line_detect_flags & line_source_enable;
  wire       keypad_group_enable =
    int_enable_extended[BIT_KEYPAD_GROUP];
  wire       keypad_group_priority =
    int_priority_extended[BIT_KEYPAD_GROUP];
  wire       keypad_req   = |line_request;

  // ---------------------------------------------------------------------
  // Priority resolution
  // ---------------------------------------------------------------------
  wire [7:0] src_req = {i_counter_array_req, keypad_req,
                        i_periph_req};
  wire [7:0] src_en  = {int_enable_extended[BIT_COUNTER_ARRAY],
                        keypad_group_enable,
                        int_enable_main[5:0]};
  wire [7:0] src_pri = {int_priority_extended[1:0],
                        int_priority_main[5:0]};
  wire       global_int_enable = int_enable_main[BIT_GLOBAL_INT_ENABLE];
  wire [7:0] pend    = src_req & src_en & {8{global_int_enable}};
  wire [7:0] pend_hi = pend & src_pri;
  wire [7:0] pend_lo = pend & ~src_pri;
  // High requests win over low; a low one waits for all handlers.
  wire       take_hi = (|pend_hi) & ~high_active;
  wire       take_lo = (|pend_lo) & ~high_active & ~low_active
                     & ~(|pend_hi);
  wire [2:0] win_idx = take_hi ? first_set(pend_hi) : first_set(pend_lo);

  assign o_irq = take_hi | take_lo;
  assign o_irq_source = win_idx;
  assign o_irq_vector = VECTOR_BASE
                      + 16'(VECTOR_STEP * {13'h0000, win_idx});
  assign o_keypad_line_enable = line_source_enable;
  assign o_expanded_keypad_interrupt = keypad_req & keypad_group_enable;
  // Wake does not need the clock-gated core, only a flagged enabled line.
  assign o_wake = keypad_req;
  assign o_sfr_hit = any_sel;
  assign o_active_level = kic_level_t'({high_active, low_active});

  wire [7:0] rd_mux =
      sel_iem ? int_enable_main
    : sel_iex ? int_enable_extended
    : sel_ipm ? int_priority_main
    : sel_ipx ? int_priority_extended
    : sel_pol ? line_level_polarity
    : sel_sen ? line_source_enable
    : sel_flg ? line_detect_flags
    : RST_REG;

  // ---------------------------------------------------------------------
  // Sequential logic
  // ---------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    port_sync1 <= i_port1;
    port_sync2 <= port_sync1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      int_enable_main       <= RST_REG;
      int_enable_extended   <= RST_REG;
      int_priority_main     <= RST_REG;
      int_priority_extended <= RST_REG;
      line_level_polarity   <= RST_REG;
      line_source_enable    <= RST_REG;
    end else if (i_sfr_wr) begin
      if (sel_iem) int_enable_main <= i_sfr_wdata & MASK_ENABLE_MAIN;
      if (sel_iex) int_enable_extended <= i_sfr_wdata & MASK_LOW_TWO;
      if (sel_ipm) int_priority_main <= i_sfr_wdata & MASK_LOW_SIX;
      if (sel_ipx) int_priority_extended <= i_sfr_wdata & MASK_LOW_TWO;
      if (sel_pol) line_level_polarity <= i_sfr_wdata;
      if (sel_sen) line_source_enable <= i_sfr_wdata;
    end
  end

  // Reading clears; a line still matching sets again in the same cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      line_detect_flags <= RST_REG;
    end else begin
      line_detect_flags <= next_flags;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_sfr_rdata <= RST_REG;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_mux;
    end
  end

  // Handler nesting: a return ends the highest active level first.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      high_active <= 1'b0;
      low_active  <= 1'b0;
    end else if (i_irq_ack && o_irq) begin
      if (take_hi) high_active <= 1'b1;
      else low_active <= 1'b1;
    end else if (i_reti) begin
      if (high_active) high_active <= 1'b0;
      else low_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  sequence s_flag_read;
    flag_rd && !(|line_match);
  endsequence

  chk_flag_clear_read: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) s_flag_read |=> line_detect_flags == 8'h00)
    else $error("flags not cleared by read");

  chk_flag_write_ignored: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (i_sfr_wr && sel_flg && !flag_rd
      && !(|line_match)) |=> line_detect_flags == $past(line_detect_flags))
    else $error("flag write changed flags");

  chk_level_sets_flag: assert property (@(posedge i_sys_clk)
    disable iff (i_srst)
    ((i_port1[0] == line_level_polarity[0] && !i_sfr_wr) ##1 !i_sfr_wr)
      |=> ##1 line_detect_flags[0])
    else $error("matching level did not set flag");

  chk_global_gate: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) !global_int_enable |-> !o_irq)
    else $error("irq without global enable");

  chk_keypad_gate: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (line_source_enable == 8'h00) |-> !keypad_req)
    else $error("keypad request with no line enabled");

  chk_keypad_vector: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (o_irq && o_irq_source == 3'(SRC_KEYPAD))
      |-> o_irq_vector == 16'h0033)
    else $error("keypad vector wrong");

  chk_low_no_preempt: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (high_active && o_irq)
      |-> 1'b0)
    else $error("request granted during high handler");

  chk_high_first: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (o_irq && |pend_hi)
      |-> src_pri[o_irq_source])
    else $error("low request chosen over high");

  chk_sync_delay: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) port_sync2 == $past(i_port1, 2))
    else $error("synchroniser depth wrong");

  // ---------------------------------------------------------------------
  // Handler nesting and register checks
  // ---------------------------------------------------------------------
  // A grant marks one level; a return ends the highest level first.
  sequence s_high_grant;
    i_irq_ack && take_hi;
  endsequence

  sequence s_low_grant;
    i_irq_ack && take_lo;
  endsequence

  sequence s_high_return;
    i_reti && !i_irq_ack && high_active;
  endsequence

  sequence s_low_return;
    i_reti && !i_irq_ack && !high_active && low_active;
  endsequence

  chk_high_grant_latch: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) s_high_grant |=> high_active)
    else $error("high grant did not mark handler");

  chk_low_grant_latch: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) s_low_grant |=> low_active && !high_active)
    else $error("low grant did not mark handler");

  chk_high_return: assert property (@(posedge i_sys_clk)
    disable iff (i_srst)
    s_high_return |=> !high_active && low_active == $past(low_active))
    else $error("return did not end the high handler");

  chk_low_return: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) s_low_return |=> !low_active && !high_active)
    else $error("return did not end the low handler");

  chk_low_waits_low: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (low_active && o_irq) |-> src_pri[o_irq_source])
    else $error("low request granted during low handler");

  chk_enable_gate: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) o_irq
      |-> src_en[o_irq_source] && src_req[o_irq_source])
    else $error("granted source not enabled or not requesting");

  chk_low_poll_order: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (o_irq && !(|pend_hi))
      |-> (pend_lo & ~(8'hFF << o_irq_source)) == 8'h00)
    else $error("low request not first in polling order");

  chk_high_poll_order: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (o_irq && |pend_hi)
      |-> (pend_hi & ~(8'hFF << o_irq_source)) == 8'h00)
    else $error("high request not first in polling order");

  chk_vector_grid: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) o_irq
      |-> o_irq_vector[2:0] == 3'h3 && o_irq_vector[15:6] == 10'h000)
    else $error("vector off the eight byte grid");

  chk_reserved_zero: assert property (@(posedge i_sys_clk)
    disable iff (i_srst)
    !int_enable_main[6] && int_priority_main[7:6] == 2'h0
      && int_enable_extended[7:2] == 6'h00
      && int_priority_extended[7:2] == 6'h00)
    else $error("reserved enable or priority bit set");

  chk_group_gate: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) !keypad_group_enable
      |-> !o_expanded_keypad_interrupt
      && !(o_irq && o_irq_source == 3'(SRC_KEYPAD)))
    else $error("keypad group request while group disabled");

  chk_group_request: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) o_expanded_keypad_interrupt
      |-> (line_detect_flags & line_source_enable) != 8'h00)
    else $error("keypad group request without enabled flag");

  chk_wake_needs_line: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) o_wake |-> line_source_enable != 8'h00)
    else $error("wake with no keypad line enabled");

  chk_read_flags: assert property (@(posedge i_sys_clk)
    disable iff (i_srst)
    flag_rd |=> o_sfr_rdata == $past(line_detect_flags))
    else $error("flag read returned wrong data");

  chk_flag_sticky: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) !flag_rd
      |=> (line_detect_flags & $past(line_detect_flags))
        == $past(line_detect_flags))
    else $error("flag lost without a read");

  chk_rdata_hold: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) !i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");

  chk_polarity_write: assert property (@(posedge i_sys_clk)
    disable iff (i_srst) (i_sfr_wr && sel_pol)
      |=> line_level_polarity == $past(i_sfr_wdata))
    else $error("polarity write did not land");

endmodule

// >>> test/kic_partner.sv
`timescale 1ns/1ps
// Keypad lines with pull-ups plus peripherals holding level requests.
module kic_partner (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_keys_down,
  input  wire logic [7:0] i_req_set,
  input  wire logic [7:0] i_req_clr,
  output logic      [7:0] o_port1,
  output logic      [5:0] o_periph_req,
  output logic            o_counter_array_req
);
  logic [7:0] req = 8'h00;
  // A pressed key pulls its line low; a released line floats high.
  assign o_port1 = ~i_keys_down;
  // Requests stay up until software on the far side clears them.
  always_ff @(posedge i_sys_clk) begin
    req <= (req | i_req_set) & ~i_req_clr;
  end
  assign o_periph_req        = req[5:0];
  assign o_counter_array_req = req[7];
endmodule

// >>> test/test_kic_ctrl.sv
`timescale 1ns/1ps
module test_kic_ctrl;
  import kic_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_srst    = 1'b1;
  logic [7:0]  a_r = 8'h00, wd_r = 8'h00, keys = 8'h00;
  logic [7:0]  rset = 8'h00, rclr = 8'h00;
  logic        wr_r = 1'b0, rd_r = 1'b0, ack_r = 1'b0, reti_r = 1'b0;
  logic [7:0]  rdata, port1, kle;
  logic [5:0]  preq;
  logic        careq, irq, wake, eki, hit;
  logic [15:0] vec;
  logic [2:0]  src;
  kic_level_t  lvl;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  logic [7:0]  at [7] = '{8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hFF, 8'hFD, 8'hFE};
  logic [7:0]  mt [7] = '{8'hBF, 8'h03, 8'h3F, 8'h03, 8'h00, 8'hFF, 8'hFF};

  always #5 i_sys_clk = ~i_sys_clk;

  kic_partner u_kic_partner (.i_sys_clk(i_sys_clk), .i_keys_down(keys),
    .i_req_set(rset), .i_req_clr(rclr), .o_port1(port1),
    .o_periph_req(preq), .o_counter_array_req(careq));

  kic_ctrl u_kic_ctrl (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_sfr_addr(a_r), .i_sfr_wr(wr_r), .i_sfr_rd(rd_r),
    .i_sfr_wdata(wd_r), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .i_port1(port1), .i_periph_req(preq), .i_counter_array_req(careq),
    .o_irq(irq), .o_irq_vector(vec), .o_irq_source(src),
    .i_irq_ack(ack_r), .i_reti(reti_r), .o_keypad_line_enable(kle),
    .o_wake(wake), .o_expanded_keypad_interrupt(eki),
    .o_active_level(lvl));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    a_r <= a; wd_r <= d; wr_r <= 1'b1;
    @(posedge i_sys_clk);
    wr_r <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    a_r <= a; rd_r <= 1'b1;
    @(posedge i_sys_clk);
    rd_r <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic pulse(input logic is_ack);
    @(posedge i_sys_clk);
    if (is_ack) ack_r <= 1'b1; else reti_r <= 1'b1;
    @(posedge i_sys_clk);
    ack_r <= 1'b0; reti_r <= 1'b0;
    #1;
  endtask

  // Reset values, reserved bits, and the read-only flag register.
  task automatic t_regs;
    for (int i = 0; i < 7; i++) rd(at[i], 8'h00);
    rd(8'h80, 8'h00);
    chk(hit, 1'b0);
    for (int i = 0; i < 7; i++) begin
      wr(at[i], 8'hFF);
      rd(at[i], mt[i]);
      chk(hit, 1'b1);
    end
    for (int i = 0; i < 7; i++) wr(at[i], 8'h00);
    tick(4);
    rd(8'hFF, 8'hFF);
    rd(8'hFF, 8'h00);
  endtask

  // Per-line detection, enable gating and clear on read.
  task automatic t_keypad;
    wr(8'hFE, 8'h05);
    chk(kle, 8'h05);
    keys <= 8'h04;
    tick(4);
    chk(wake, 1'b1);
    chk(eki, 1'b0);
    keys <= 8'h00;
    tick(4);
    rd(8'hFF, 8'h04);
    rd(8'hFF, 8'h00);
    keys <= 8'h08;
    tick(4);
    chk(wake, 1'b0);
    keys <= 8'h00;
    tick(4);
    rd(8'hFF, 8'h08);
    wr(8'hFD, 8'h80);
    tick(4);
    rd(8'hFF, 8'h80);
    wr(8'hFD, 8'h00);
    tick(4);
    rd(8'hFF, 8'h80);
  endtask

  // Enables, vectors, polling order, priority and nesting.
  task automatic t_irq;
    wr(8'hFE, 8'h01);
    wr(8'hFD, 8'h01);
    wr(8'hA9, 8'h01);
    tick(3);
    chk(irq, 1'b0);
    wr(8'hA8, 8'h80);
    chk(vec, 16'h0033);
    chk(src, 3'h6);
    chk(eki, 1'b1);
    wr(8'hA9, 8'h00);
    for (int n = 0; n < 6; n++) begin
      @(posedge i_sys_clk) rset <= 8'h01 << n;
      wr(8'hA8, 8'h80 | (8'h01 << n));
      chk(vec, 16'h0003 + 16'(8 * n));
      @(posedge i_sys_clk) rclr <= 8'h01 << n;
      @(posedge i_sys_clk) begin rset <= 8'h00; rclr <= 8'h00; end
    end
    @(posedge i_sys_clk) rset <= 8'hBF;
    @(posedge i_sys_clk) rset <= 8'h00;
    wr(8'hA8, 8'h80);
    wr(8'hA9, 8'h02);
    chk(vec, 16'h003B);
    wr(8'hA8, 8'hBF);
    wr(8'hA9, 8'h03);
    chk(vec, 16'h0003);
    wr(8'hB9, 8'h02);
    chk(vec, 16'h003B);
    pulse(1'b1);
    chk(lvl, KIC_HIGH_ACTIVE);
    chk(irq, 1'b0);
    pulse(1'b0);
    wr(8'hB9, 8'h00);
    pulse(1'b1);
    chk(lvl, KIC_LOW_ACTIVE);
    wr(8'hB8, 8'h20);
    chk(vec, 16'h002B);
    pulse(1'b1);
    chk(lvl, KIC_BOTH_ACTIVE);
    chk(irq, 1'b0);
    pulse(1'b0);
    chk(lvl, KIC_LOW_ACTIVE);
    pulse(1'b0);
    chk(lvl, KIC_IDLE);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_regs();
    t_keypad();
    t_irq();
    end_sim();
  end
endmodule
